// *** iesl_error_logger.sv ***
// Purpose: Machine-check status banks for three link interconnect agents.
// Assumes: Detectors run on core_clk and give one-cycle event pulses.
// Notes: Avalon-MM slave with waitrequest; one answer per request.

// Notes on behaviour
// - Three identical banks, one per agent
// - Bits 15:0 hold bus-format compound code
// - Compound code 0C0F bad packet, else 0E0F
// - Phy uncorrectable codes 00H, 01H, 02H
// - Failed retry abort logs 10H
// - Log 11H, 12H, 13H link uncorrectables
// - Mesh control error logs 1FH
// - Phy init abort 20H, phy reset 21H
// - Lane failure with x8 recovery 22H
// - Control flit errors 23H, 24H, 25H
// - Retry success 30H, with reinit 31H
// - Reserved codes are never logged
// - Detail bits 31:22 only for 12H
// - Detail bits 22, 23, 24 as defined
// - Detail bits 25, 26, 27 as defined
// - Detail bit 28 on fifo credit fault
// - Detail bit 29 on late link reset
// - Detail bit 30 busy reset, 31 parity
// - Bits 63:57 hold VAL, OVER, UC, EN, MISCV, ADDRV, PCC flags
module iesl_error_logger
   import iesl_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [iesl_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [iesl_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [iesl_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [iesl_pkg::NUM_BANKS-1:0] errValid,
   input wire logic [iesl_pkg::NUM_BANKS*iesl_pkg::CODE_W-1:0] errCode,
   input wire logic [iesl_pkg::NUM_BANKS*iesl_pkg::DETAIL_W-1:0] errDetail,
   output logic [iesl_pkg::NUM_BANKS-1:0] bankValid
);
   import iesl_pkg::*;

   // Codes outside the defined set are dropped, never stored
   function automatic logic isDefined(input logic [CODE_W-1:0] c);
      logic ok;
      ok = 1'b0;
      case (c)
         MS_PHY_INIT_FAIL, MS_PHY_DRIFT_ALARM,
         MS_PHY_LATENCY_ROLL: ok = 1'b1;
         MS_RETRY_ABORT: ok = 1'b1;
         MS_BAD_PACKET, MS_CONTROL_ERROR,
         MS_PARAM_EXCHANGE: ok = 1'b1;
         MS_MESH_CONTROL: ok = 1'b1;
         MS_PHY_INIT_ABORT, MS_PHY_RESET: ok = 1'b1;
         MS_LANE_FAIL_X8: ok = 1'b1;
         MS_CTRL_FLIT_NO_RST, MS_CTRL_FLIT_RST,
         MS_PARTIAL_EXIT_RST: ok = 1'b1;
         MS_RETRY_OK, MS_RETRY_OK_REINIT: ok = 1'b1;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   // Uncorrectable codes all sit below the correctable base
   function automatic logic isUncorr(input logic [CODE_W-1:0] c);
      return c < MS_COR_BASE;
   endfunction

   // Fold one event into a status word
   function automatic logic [STAT_W-1:0] logEvent(
      input logic [STAT_W-1:0] s,
      input logic [CODE_W-1:0] c,
      input logic [DETAIL_W-1:0] det
   );
      logic [STAT_W-1:0] r;
      logic uc;
      logic [CNT_W-1:0] cnt;
      r = s;
      uc = isUncorr(c);
      cnt = s[COUNT_MSB:COUNT_LSB];
      // Saturate rather than wrap so a storm never reads as quiet
      if (!uc && cnt != COUNT_MAX)
      begin
         r[COUNT_MSB:COUNT_LSB] = cnt + 1'b1;
      end
      // A corrected entry yields to an uncorrectable one, never back
      if (!s[BIT_VAL] || (uc && !s[BIT_UC]))
      begin
         if (c == MS_BAD_PACKET)
         begin
            r[COMPOUND_MSB:COMPOUND_LSB] = COMPOUND_BAD_PACKET;
         end
         else
         begin
            r[COMPOUND_MSB:COMPOUND_LSB] = COMPOUND_OTHER;
         end
         r[MSCODE_MSB:MSCODE_LSB] = c;
         if (c == MS_CONTROL_ERROR)
         begin
            // Detector bit order maps straight onto 31:22
            r[DETAIL_MSB:DETAIL_LSB] = det;
         end
         else
         begin
            r[DETAIL_MSB:DETAIL_LSB] = '0;
         end
         r[BIT_VAL] = 1'b1;
         r[BIT_UC] = uc;
         r[BIT_EN] = 1'b1;
         r[BIT_MISCV] = 1'b0;
         r[BIT_ADDRV] = 1'b0;
         r[BIT_PCC] = 1'b0;
         r[BIT_OVER] = s[BIT_VAL];
      end
      else
      begin
         r[BIT_OVER] = 1'b1;
      end
      return r & STAT_WRITE_MASK;
   endfunction

   // Byte-lane merge for a 32-bit write
   function automatic logic [DATA_W-1:0] mergeBytes(
      input logic [DATA_W-1:0] old,
      input logic [DATA_W-1:0] wd,
      input logic [3:0] be
   );
      logic [DATA_W-1:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (be[b])
         begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction

   logic [STAT_W-1:0] stat_q [NUM_BANKS];
   logic [STAT_W-1:0] stat_d [NUM_BANKS];
   logic [NUM_BANKS-1:0] logEnable_q;
   logic [NUM_BANKS-1:0] logEnable_d;
   iesl_bus_e busState_q;
   logic [DATA_W-1:0] readData_q;
   logic waitReq_q;
   logic [NUM_BANKS-1:0] bankValid_q;
   logic writeTake;
   logic readTake;
   logic [DATA_W-1:0] readMux;
   logic [DATA_W-1:0] enMerge;

   // Write lands on the edge where waitrequest is sampled low
   assign writeTake = avs_write && (busState_q == BUS_ANSWER);
   assign readTake = avs_read && (busState_q == BUS_IDLE);

   always_comb
   begin
      readMux = READ_ZERO;
      for (int k = 0; k < NUM_BANKS; k++)
      begin
         if (avs_address == OFS_BANK0_LO + ADDR_W'(k) * BANK_STRIDE)
         begin
            readMux = stat_q[k][DATA_W-1:0];
         end
         if (avs_address == OFS_BANK0_HI + ADDR_W'(k) * BANK_STRIDE)
         begin
            readMux = stat_q[k][STAT_W-1:DATA_W];
         end
      end
      if (avs_address == OFS_LOG_ENABLE)
      begin
         readMux = {{(DATA_W-NUM_BANKS){1'b0}}, logEnable_q};
      end
   end

   always_comb
   begin
      // A call result cannot be sliced, so merge into a word first
      enMerge = mergeBytes({{(DATA_W-NUM_BANKS){1'b0}}, logEnable_q},
         avs_writedata, avs_byteenable);
      logEnable_d = logEnable_q;
      if (writeTake && avs_address == OFS_LOG_ENABLE)
      begin
         logEnable_d = enMerge[NUM_BANKS-1:0];
      end
   end

   // Software write first, then the event, so an event is never lost
   always_comb
   begin
      for (int k = 0; k < NUM_BANKS; k++)
      begin
         stat_d[k] = stat_q[k];
         if (writeTake && avs_address == OFS_BANK0_LO + ADDR_W'(k) * BANK_STRIDE)
         begin
            stat_d[k][DATA_W-1:0] = mergeBytes(stat_q[k][DATA_W-1:0],
               avs_writedata, avs_byteenable);
         end
         if (writeTake && avs_address == OFS_BANK0_HI + ADDR_W'(k) * BANK_STRIDE)
         begin
            stat_d[k][STAT_W-1:DATA_W] = mergeBytes(stat_q[k][STAT_W-1:DATA_W],
               avs_writedata, avs_byteenable);
         end
         stat_d[k] = stat_d[k] & STAT_WRITE_MASK;
         if (errValid[k] && logEnable_q[k]
            && isDefined(errCode[k*CODE_W +: CODE_W]))
         begin
            stat_d[k] = logEvent(stat_d[k], errCode[k*CODE_W +: CODE_W],
               errDetail[k*DETAIL_W +: DETAIL_W]);
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int k = 0; k < NUM_BANKS; k++)
         begin
            stat_q[k] <= STAT_RESET;
         end
      end
      else
      begin
         for (int k = 0; k < NUM_BANKS; k++)
         begin
            stat_q[k] <= stat_d[k];
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         logEnable_q <= LOG_ENABLE_RESET;
      end
      else
      begin
         logEnable_q <= logEnable_d;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bankValid_q <= '0;
      end
      else
      begin
         for (int k = 0; k < NUM_BANKS; k++)
         begin
            bankValid_q[k] <= stat_d[k][BIT_VAL];
         end
      end
   end

   // Every request gets exactly one low-waitrequest cycle
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busState_q <= BUS_IDLE;
         waitReq_q <= 1'b1;
         readData_q <= READ_ZERO;
      end
      else
      begin
         case (busState_q)
            BUS_IDLE:
            begin
               if (avs_read || avs_write)
               begin
                  busState_q <= BUS_ANSWER;
                  waitReq_q <= 1'b0;
               end
               if (readTake)
               begin
                  readData_q <= readMux;
               end
            end
            BUS_ANSWER:
            begin
               busState_q <= BUS_IDLE;
               waitReq_q <= 1'b1;
            end
            default:
            begin
               busState_q <= BUS_IDLE;
               waitReq_q <= 1'b1;
            end
         endcase
      end
   end

   assign avs_readdata = readData_q;
   assign avs_waitrequest = waitReq_q;
   assign bankValid = bankValid_q;

endmodule // iesl_error_logger

// *** iesl_pkg.sv ***
// Purpose: Constants for the interconnect error status logger.
// Assumes: Three link agents, 64-bit status word, 32-bit register bus.
// Notes: Bus offsets are byte addresses of aligned 32-bit words.
package iesl_pkg;

   localparam int NUM_BANKS = 3;
   localparam int CODE_W = 6;
   localparam int DETAIL_W = 10;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam int STAT_W = 64;
   localparam int CNT_W = 15;

   // Register map, byte addresses
   localparam logic [ADDR_W-1:0] OFS_BANK0_LO = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_BANK0_HI = 5'h04;
   localparam logic [ADDR_W-1:0] BANK_STRIDE = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_LOG_ENABLE = 5'h18;

   // Status word fields
   localparam int COMPOUND_LSB = 0;
   localparam int COMPOUND_MSB = 15;
   localparam int MSCODE_LSB = 16;
   localparam int MSCODE_MSB = 21;
   localparam int DETAIL_LSB = 22;
   localparam int DETAIL_MSB = 31;
   localparam int COUNT_LSB = 38;
   localparam int COUNT_MSB = 52;
   localparam int BIT_PCC = 57;
   localparam int BIT_ADDRV = 58;
   localparam int BIT_MISCV = 59;
   localparam int BIT_EN = 60;
   localparam int BIT_UC = 61;
   localparam int BIT_OVER = 62;
   localparam int BIT_VAL = 63;

   // Writable bits of the status word; reserved 37:32 and 56:53 stay zero
   localparam logic [STAT_W-1:0] STAT_WRITE_MASK = 64'hfe1f_ffc0_ffff_ffff;
   localparam logic [STAT_W-1:0] STAT_RESET = 64'h0000_0000_0000_0000;
   localparam logic [NUM_BANKS-1:0] LOG_ENABLE_RESET = 3'h7;
   localparam logic [CNT_W-1:0] COUNT_MAX = 15'h7fff;
   localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

   // Compound error codes
   localparam logic [15:0] COMPOUND_BAD_PACKET = 16'h0c0f;
   localparam logic [15:0] COMPOUND_OTHER = 16'h0e0f;

   // Model-specific error codes, uncorrectable
   localparam logic [CODE_W-1:0] MS_PHY_INIT_FAIL = 6'h00;
   localparam logic [CODE_W-1:0] MS_PHY_DRIFT_ALARM = 6'h01;
   localparam logic [CODE_W-1:0] MS_PHY_LATENCY_ROLL = 6'h02;
   localparam logic [CODE_W-1:0] MS_RETRY_ABORT = 6'h10;
   localparam logic [CODE_W-1:0] MS_BAD_PACKET = 6'h11;
   localparam logic [CODE_W-1:0] MS_CONTROL_ERROR = 6'h12;
   localparam logic [CODE_W-1:0] MS_PARAM_EXCHANGE = 6'h13;
   localparam logic [CODE_W-1:0] MS_MESH_CONTROL = 6'h1f;
   // Model-specific error codes, correctable
   localparam logic [CODE_W-1:0] MS_COR_BASE = 6'h20;
   localparam logic [CODE_W-1:0] MS_PHY_INIT_ABORT = 6'h20;
   localparam logic [CODE_W-1:0] MS_PHY_RESET = 6'h21;
   localparam logic [CODE_W-1:0] MS_LANE_FAIL_X8 = 6'h22;
   localparam logic [CODE_W-1:0] MS_CTRL_FLIT_NO_RST = 6'h23;
   localparam logic [CODE_W-1:0] MS_CTRL_FLIT_RST = 6'h24;
   localparam logic [CODE_W-1:0] MS_PARTIAL_EXIT_RST = 6'h25;
   localparam logic [CODE_W-1:0] MS_RETRY_OK = 6'h30;
   localparam logic [CODE_W-1:0] MS_RETRY_OK_REINIT = 6'h31;

   // Detail bitmap positions, relative to DETAIL_LSB
   localparam int DET_PHY_CONTROL = 0;
   localparam int DET_RETRY_ACK = 1;
   localparam int DET_RETRY_REQ = 2;
   localparam int DET_RF_PARITY = 3;
   localparam int DET_ROUTEBACK = 4;
   localparam int DET_TX_PROTOCOL = 5;
   localparam int DET_FIFO_CREDIT = 6;
   localparam int DET_RESET_LATE = 7;
   localparam int DET_RESET_BUSY = 8;
   localparam int DET_TX_PARITY = 9;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ANSWER = 2'b01
   } iesl_bus_e;

endpackage

// *** iesl_error_logger_props.sv ***
// Purpose: Port checks for the interconnect status logger.
// Assumes: Software never sets a valid bit by a write.
// Notes: Valid bits change on the same edge as the status word.
module iesl_error_logger_props
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [iesl_pkg::DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [iesl_pkg::NUM_BANKS-1:0] errValid,
   input wire logic [iesl_pkg::NUM_BANKS*iesl_pkg::CODE_W-1:0] errCode,
   input wire logic [iesl_pkg::NUM_BANKS-1:0] bankValid
);
   import iesl_pkg::*;
   logic rsv0;
   assign rsv0 = !(errCode[5:0] inside {6'h00, 6'h01, 6'h02, 6'h10,
      6'h11, 6'h12, 6'h13, 6'h1f, [6'h20:6'h25], 6'h30, 6'h31});
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   chk_wait_one_low:
      assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("Wait request low too long");
   chk_req_answer:
      assert property ((avs_read || avs_write) && avs_waitrequest
         |=> !avs_waitrequest) else $error("No answer to request");
   chk_idle_waits:
      assert property (!(avs_read || avs_write) && avs_waitrequest
         |=> avs_waitrequest) else $error("Answer without request");
   chk_rdata_hold:
      assert property (avs_waitrequest |-> $stable(avs_readdata))
      else $error("Read data moved outside an answer");
   chk_valid_cause0:
      assert property ($rose(bankValid[0]) |-> $past(errValid[0], 1))
      else $error("Bank 0 valid without event");
   chk_valid_cause1:
      assert property ($rose(bankValid[1]) |-> $past(errValid[1], 1))
      else $error("Bank 1 valid without event");
   chk_valid_cause2:
      assert property ($rose(bankValid[2]) |-> $past(errValid[2], 1))
      else $error("Bank 2 valid without event");
   chk_reserved_drop:
      assert property (!bankValid[0] && errValid[0] && rsv0
         && !$past(errValid[0]) ##1 !errValid[0] |=> !bankValid[0])
      else $error("Reserved code was logged");
   chk_valid_clear:
      assert property ($fell(bankValid[0]) |-> $past(avs_write, 1)
         && !$past(avs_waitrequest, 1)) else $error("Valid fell alone");
endmodule // iesl_error_logger_props
bind iesl_error_logger iesl_error_logger_props props (.core_clk, .rst_n,
   .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .errValid,
   .errCode, .bankValid);

// *** iesl_detector_model.sv ***
// Purpose: Stand-in for the link error detectors of three agents.
// Assumes: Events are one-cycle pulses on core_clk.
// Notes: Idle code lines show inverted data, never the old value.
module iesl_detector_model
(
   input wire logic core_clk,
   output logic [iesl_pkg::NUM_BANKS-1:0] errValid,
   output logic [iesl_pkg::NUM_BANKS*iesl_pkg::CODE_W-1:0] errCode,
   output logic [iesl_pkg::NUM_BANKS*iesl_pkg::DETAIL_W-1:0] errDetail
);
   import iesl_pkg::*;
   initial
   begin
      errValid = '0;
      errCode = '0;
      errDetail = '0;
   end
   // Late-reset detail is the detectors' own; training waits on reset flag
   // Pulse held on when the caller chains another event
   task automatic fire(input int b, input logic [5:0] c,
         input logic [9:0] d, input logic last);
      errValid[b] <= 1'b1;
      errCode[6*b +: 6] <= c;
      errDetail[10*b +: 10] <= d;
      @(posedge core_clk);
      if (last)
      begin
         errValid[b] <= 1'b0;
         errCode[6*b +: 6] <= ~c;
         errDetail[10*b +: 10] <= ~d;
      end
   endtask
endmodule // iesl_detector_model

// *** iesl_error_logger_tb.sv ***
// Purpose: Self-checking bench for the interconnect status logger.
// Assumes: Reads queue their expectation; a monitor compares.
// Notes: A bank is cleared before each single event and before the three-event chain.
module iesl_error_logger_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import iesl_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [DATA_W-1:0] avs_writedata = '0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [DATA_W-1:0] avs_readdata;
   logic avs_waitrequest;
   logic [NUM_BANKS-1:0] errValid;
   logic [NUM_BANKS-1:0] bankValid;
   logic [NUM_BANKS*CODE_W-1:0] errCode;
   logic [NUM_BANKS*DETAIL_W-1:0] errDetail;
   logic [31:0] expQ[$];
   int miscompares = 0;
   int check_count = 0;
   iesl_error_logger dut (.core_clk, .rst_n, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
      .avs_waitrequest, .errValid, .errCode, .errDetail, .bankValid);
   iesl_detector_model det (.core_clk, .errValid, .errCode, .errDetail);
   initial
   begin
      forever #20 core_clk = ~core_clk;
   end
   task automatic test_done();
      $display("Checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [63:0] s, e);
      check_count++;
      if (s !== e)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic bus(input int a, input logic w, input logic [31:0] d,
         input logic [3:0] be);
      int n;
      n = 0;
      avs_address <= 5'(a);
      avs_read <= !w;
      avs_write <= w;
      avs_writedata <= d;
      avs_byteenable <= be;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      if (avs_waitrequest !== 1'b0)
      begin
         miscompares++;
         test_done();
      end
      else
      begin
         avs_read <= 1'b0;
         avs_write <= 1'b0;
         @(posedge core_clk);
      end
   endtask
   task automatic rd(input int a, input logic [31:0] e);
      expQ.push_back(e);
      bus(a, 1'b0, 32'h0, 4'hf);
   endtask
   function automatic logic [63:0] expw(input logic [5:0] c,
         input logic [9:0] d, input logic [14:0] n);
      expw = {1'b1, 1'b0, c < 6'h20, 1'b1, 7'h0, n, 6'h0,
         (c == 6'h12) ? d : 10'h0, c, (c == 6'h11) ? 16'h0c0f : 16'h0e0f};
   endfunction
   task automatic logone(input int b, input logic [5:0] c,
         input logic [9:0] d, input logic [63:0] e);
      bus(8 * b, 1'b1, 32'h0, 4'hf);
      bus(8 * b + 4, 1'b1, 32'h0, 4'hf);
      det.fire(b, c, d, 1'b1);
      repeat (2) @(posedge core_clk);
      check("bankValid", bankValid[b], e[63]);
      rd(8 * b, e[31:0]);
      rd(8 * b + 4, e[63:32]);
   endtask
   always @(posedge core_clk)
   begin
      if (avs_read && avs_waitrequest === 1'b0)
         check("readdata", avs_readdata, expQ.pop_front());
   end
   initial
   begin
      logic [5:0] codes[17];
      logic [5:0] rsv[8];
      logic [5:0] c;
      logic [9:0] d;
      logic [63:0] e;
      codes = '{6'h00, 6'h01, 6'h02, 6'h10, 6'h11, 6'h12, 6'h13, 6'h1f,
         6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h30, 6'h31, 6'h12};
      rsv = '{6'h03, 6'h0f, 6'h14, 6'h1e, 6'h26, 6'h2f, 6'h32, 6'h3f};
      void'($urandom(74565));
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      for (int a = 0; a < 32; a += 4)
         rd(a, (a == 24) ? 32'h7 : 32'h0);
      for (int i = 0; i < 27; i++)
      begin
         c = (i < 17) ? codes[i] : 6'h12;
         d = (i < 17) ? 10'($urandom) : 10'(1 << (i - 17));
         e = expw(c, d, 15'(c >= 6'h20));
         logone(i % 3, c, d, e);
      end
      foreach (rsv[j])
         logone(j % 3, rsv[j], 10'h3ff, 64'h0);
      bus(0, 1'b1, 32'h0, 4'hf);
      bus(4, 1'b1, 32'h0, 4'hf);
      d = 10'($urandom);
      det.fire(0, 6'h12, d, 1'b0);
      det.fire(0, 6'h20, 10'h0, 1'b0);
      det.fire(0, 6'h21, 10'h0, 1'b1);
      e = expw(6'h12, d, 15'h2) | 64'h4000_0000_0000_0000;
      rd(0, e[31:0]);
      rd(4, e[63:32]);
      bus(24, 1'b1, 32'h6, 4'hf);
      rd(24, 32'h6);
      logone(0, 6'h30, 10'h0, 64'h0);
      bus(24, 1'b1, 32'h7, 4'hf);
      bus(16, 1'b1, 32'h0, 4'hf);
      bus(16, 1'b1, 32'hffff_ffff, 4'h3);
      bus(20, 1'b1, 32'h7fff_ffff, 4'hf);
      bus(28, 1'b1, 32'hffff_ffff, 4'hf);
      rd(16, 32'h0000_ffff);
      rd(20, 32'h7e1f_ffc0);
      rd(28, 32'h0);
      rd(24, 32'h7);
      check("queue", expQ.size(), 64'h0);
      test_done();
   end
endmodule // iesl_error_logger_tb
